// [src/jtp_fifo.sv]
`timescale 1ns/1ns
module jtp_fifo #(
	parameter int W = 22,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	// Storage
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end

	// Pointers
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule : jtp_fifo

// [src/jtp_pkg.sv]
package jtp_pkg;
	// Instruction register and its codes
	localparam int IR_W = 4;
	localparam logic [3:0] IR_BYPASS = 4'hf;
	localparam logic [3:0] IR_IDCODE = 4'h1;
	localparam logic [3:0] IR_ENABLE = 4'h9;
	localparam logic [3:0] IR_ERASE = 4'ha;
	localparam logic [3:0] IR_PROGRAM = 4'hb;
	localparam logic [3:0] IR_VERIFY = 4'hc;
	// Standard capture pattern, low bits 01
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// Identification value; arbitrary, bit 0 must stay set
	localparam logic [31:0] ID_VALUE = 32'h0a5a_5001;
	localparam int ID_W = 32;
	// Nonvolatile array geometry
	localparam int ROW_AW = 4;
	localparam int ROW_W = 16;
	localparam int ROWS = 16;
	localparam logic [ROW_W-1:0] ROW_ERASED = 16'h0000;
	localparam logic [ROW_AW-1:0] CFG_ROW = 4'h0;
	localparam int CFG_GPIO_BIT = 0;
	// Programming shift register: address above data
	localparam int PSR_W = ROW_AW + ROW_W;
	// Commands carried to the array side
	localparam int CMD_W = 2;
	localparam logic [1:0] CMD_ERASE = 2'h0;
	localparam logic [1:0] CMD_PROGRAM = 2'h1;
	localparam logic [1:0] CMD_VERIFY = 2'h2;
	localparam int REQ_W = CMD_W + PSR_W;
	localparam int FIFO_DEPTH = 16;
	// Data register selection
	localparam logic [1:0] SEL_BYP = 2'h0;
	localparam logic [1:0] SEL_ID = 2'h1;
	localparam logic [1:0] SEL_PSR = 2'h2;

	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} jtp_tap_t;

	typedef enum logic {
		EX_IDLE, EX_ERASE
	} jtp_exec_t;
endpackage : jtp_pkg

// [src/jtp_sync.sv]
`timescale 1ns/1ns
// Two-flop level synchroniser; first stage feeds only the second
module jtp_sync (
	input wire logic clk,
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	// No reset here so it can also carry a reset into a new domain
	always_ff @(posedge clk)
	begin
		meta_reg <= din;
		dout <= meta_reg;
	end
endmodule : jtp_sync

// [src/jtp_tap_isp.sv]
`timescale 1ns/1ns
module jtp_tap_isp (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo_o,
	output logic tdo_oe_n,
	output logic pins_gpio,
	output logic prog_busy,
	output logic [jtp_pkg::ROW_W-1:0] cfg_word
);
	// Next port state from mode-select
	function automatic jtp_pkg::jtp_tap_t tap_next(
		input jtp_pkg::jtp_tap_t s,
		input logic m
	);
		jtp_pkg::jtp_tap_t n;
		n = s;
		case (s)
			jtp_pkg::TLR: n = m ? jtp_pkg::TLR : jtp_pkg::RTI;
			jtp_pkg::RTI: n = m ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_DR: n = m ? jtp_pkg::SEL_IR : jtp_pkg::CAP_DR;
			jtp_pkg::CAP_DR: n = m ? jtp_pkg::EX1_DR : jtp_pkg::SH_DR;
			jtp_pkg::SH_DR: n = m ? jtp_pkg::EX1_DR : jtp_pkg::SH_DR;
			jtp_pkg::EX1_DR: n = m ? jtp_pkg::UPD_DR : jtp_pkg::PAU_DR;
			jtp_pkg::PAU_DR: n = m ? jtp_pkg::EX2_DR : jtp_pkg::PAU_DR;
			jtp_pkg::EX2_DR: n = m ? jtp_pkg::UPD_DR : jtp_pkg::SH_DR;
			jtp_pkg::UPD_DR: n = m ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_IR: n = m ? jtp_pkg::TLR : jtp_pkg::CAP_IR;
			jtp_pkg::CAP_IR: n = m ? jtp_pkg::EX1_IR : jtp_pkg::SH_IR;
			jtp_pkg::SH_IR: n = m ? jtp_pkg::EX1_IR : jtp_pkg::SH_IR;
			jtp_pkg::EX1_IR: n = m ? jtp_pkg::UPD_IR : jtp_pkg::PAU_IR;
			jtp_pkg::PAU_IR: n = m ? jtp_pkg::EX2_IR : jtp_pkg::PAU_IR;
			jtp_pkg::EX2_IR: n = m ? jtp_pkg::UPD_IR : jtp_pkg::SH_IR;
			jtp_pkg::UPD_IR: n = m ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			default: n = jtp_pkg::TLR;
		endcase
		return n;
	endfunction : tap_next

	// True for the three array commands
	function automatic logic is_cmd(input logic [3:0] ir);
		return (ir == jtp_pkg::IR_ERASE) || (ir == jtp_pkg::IR_PROGRAM) ||
			(ir == jtp_pkg::IR_VERIFY);
	endfunction : is_cmd

	// Which data register sits between data-in and data-out
	function automatic logic [1:0] dr_sel(input logic [3:0] ir, input logic armed);
		logic [1:0] s;
		s = jtp_pkg::SEL_BYP;
		if (ir == jtp_pkg::IR_IDCODE)
			s = jtp_pkg::SEL_ID;
		else if (ir == jtp_pkg::IR_ENABLE)
			s = jtp_pkg::SEL_PSR;
		else if (is_cmd(ir) && armed)
			s = jtp_pkg::SEL_PSR;
		return s;
	endfunction : dr_sel

	// ---------------- Test clock domain ----------------
	jtp_pkg::jtp_tap_t state_reg;
	logic [jtp_pkg::IR_W-1:0] ir_sh_reg;
	logic [jtp_pkg::IR_W-1:0] ir_reg;
	logic armed_reg;
	logic bypass_reg;
	logic [jtp_pkg::ID_W-1:0] id_sh_reg;
	logic [jtp_pkg::PSR_W-1:0] psr_reg;
	logic [jtp_pkg::REQ_W-1:0] req_word_reg;
	logic req_tog_reg;
	logic tdo_o_reg;
	logic tdo_oe_n_reg;
	logic tck_nrst;
	logic gpio_tck;
	logic ack_tck;
	logic tap_hold;
	logic pending;
	logic [1:0] sel;
	logic [1:0] req_cmd;
	logic shift_bit;

	// ---------------- Reference clock domain ----------------
	logic [jtp_pkg::ROW_W-1:0] nv_mem [jtp_pkg::ROWS];
	jtp_pkg::jtp_exec_t exec_reg;
	logic [jtp_pkg::ROW_AW-1:0] erase_row_reg;
	logic [jtp_pkg::ROW_W-1:0] vdata_reg;
	logic ack_tog_reg;
	logic seen_tog_reg;
	logic cfg_load_reg;
	logic pins_gpio_reg;
	logic prog_busy_reg;
	logic [jtp_pkg::ROW_W-1:0] cfg_word_reg;
	logic req_ref;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [jtp_pkg::REQ_W-1:0] fifo_out_data;
	logic [jtp_pkg::CMD_W-1:0] op_cmd;
	logic [jtp_pkg::ROW_AW-1:0] op_addr;
	logic [jtp_pkg::ROW_W-1:0] op_data;
	logic op_take;

	// Crossings into the test clock domain
	jtp_sync u_rst_sync (
		.clk(tck),
		.din(nrst),
		.dout(tck_nrst)
	);
	jtp_sync u_gpio_sync (
		.clk(tck),
		.din(pins_gpio_reg),
		.dout(gpio_tck)
	);
	jtp_sync u_ack_sync (
		.clk(tck),
		.din(ack_tog_reg),
		.dout(ack_tck)
	);
	// Crossing into the reference domain
	jtp_sync u_req_sync (
		.clk(ref_clk),
		.din(req_tog_reg),
		.dout(req_ref)
	);

	// Port held in reset by power-up reset or when pins are freed
	assign tap_hold = !tck_nrst || gpio_tck;
	assign pending = req_tog_reg != ack_tck;
	assign sel = dr_sel(ir_reg, armed_reg);
	assign req_cmd = (ir_reg == jtp_pkg::IR_ERASE) ? jtp_pkg::CMD_ERASE :
		(ir_reg == jtp_pkg::IR_PROGRAM) ? jtp_pkg::CMD_PROGRAM : jtp_pkg::CMD_VERIFY;

	// Port state sequence on rising test clock
	always_ff @(posedge tck)
	begin
		if (tap_hold)
			state_reg <= jtp_pkg::TLR;
		else
			state_reg <= tap_next(state_reg, tms);
	end

	// Instruction shift and update
	always_ff @(posedge tck)
	begin
		if (tap_hold || state_reg == jtp_pkg::TLR)
		begin
			ir_sh_reg <= jtp_pkg::IR_CAPTURE;
			ir_reg <= jtp_pkg::IR_IDCODE;
		end
		else if (state_reg == jtp_pkg::CAP_IR)
			ir_sh_reg <= jtp_pkg::IR_CAPTURE;
		else if (state_reg == jtp_pkg::SH_IR)
			ir_sh_reg <= {tdi, ir_sh_reg[jtp_pkg::IR_W-1:1]};
		else if (state_reg == jtp_pkg::UPD_IR)
			ir_reg <= ir_sh_reg;
	end

	// Enable stays in effect across array commands only
	always_ff @(posedge tck)
	begin
		if (tap_hold || state_reg == jtp_pkg::TLR)
			armed_reg <= 1'h0;
		else if (state_reg == jtp_pkg::UPD_IR)
		begin
			if (ir_sh_reg == jtp_pkg::IR_ENABLE)
				armed_reg <= 1'h1;
			else if (!is_cmd(ir_sh_reg))
				armed_reg <= 1'h0;
		end
	end

	// One-bit bypass stage, captures zero
	always_ff @(posedge tck)
	begin
		if (tap_hold)
			bypass_reg <= 1'h0;
		else if (state_reg == jtp_pkg::CAP_DR && sel == jtp_pkg::SEL_BYP)
			bypass_reg <= 1'h0;
		else if (state_reg == jtp_pkg::SH_DR && sel == jtp_pkg::SEL_BYP)
			bypass_reg <= tdi;
	end

	// Identification shifter
	always_ff @(posedge tck)
	begin
		if (tap_hold)
			id_sh_reg <= jtp_pkg::ID_VALUE;
		else if (state_reg == jtp_pkg::CAP_DR && sel == jtp_pkg::SEL_ID)
			id_sh_reg <= jtp_pkg::ID_VALUE;
		else if (state_reg == jtp_pkg::SH_DR && sel == jtp_pkg::SEL_ID)
			id_sh_reg <= {tdi, id_sh_reg[jtp_pkg::ID_W-1:1]};
	end

	// Programming shift register; verify result enters at capture
	always_ff @(posedge tck)
	begin
		if (tap_hold)
			psr_reg <= '0;
		else if (state_reg == jtp_pkg::CAP_DR && sel == jtp_pkg::SEL_PSR &&
			ir_reg == jtp_pkg::IR_VERIFY && !pending)
			psr_reg[jtp_pkg::ROW_W-1:0] <= vdata_reg;
		else if (state_reg == jtp_pkg::SH_DR && sel == jtp_pkg::SEL_PSR)
			psr_reg <= {tdi, psr_reg[jtp_pkg::PSR_W-1:1]};
	end

	// Launch a command at update; word held until acknowledged
	always_ff @(posedge tck)
	begin
		if (tap_hold)
		begin
			req_word_reg <= '0;
			req_tog_reg <= ack_tck;
		end
		else if (state_reg == jtp_pkg::UPD_DR && sel == jtp_pkg::SEL_PSR &&
			is_cmd(ir_reg) && !pending)
		begin
			req_word_reg <= {req_cmd, psr_reg};
			req_tog_reg <= ~req_tog_reg;
		end
	end

	// Bit presented at the serial output
	always_comb
	begin
		shift_bit = bypass_reg;
		if (state_reg == jtp_pkg::SH_IR)
			shift_bit = ir_sh_reg[0];
		else if (sel == jtp_pkg::SEL_ID)
			shift_bit = id_sh_reg[0];
		else if (sel == jtp_pkg::SEL_PSR)
			shift_bit = psr_reg[0];
	end

	// Output changes on falling edge, half a cycle of hold for the next part
	always_ff @(negedge tck)
	begin
		if (tap_hold)
		begin
			tdo_o_reg <= 1'h0;
			tdo_oe_n_reg <= 1'h1;
		end
		else if (state_reg == jtp_pkg::SH_IR || state_reg == jtp_pkg::SH_DR)
		begin
			tdo_o_reg <= shift_bit;
			tdo_oe_n_reg <= 1'h0;
		end
		else
			tdo_oe_n_reg <= 1'h1;
	end

	assign tdo_o = tdo_o_reg;
	assign tdo_oe_n = tdo_oe_n_reg;

	// Reference side: accept toggled request into the queue
	assign fifo_in_valid = req_ref != seen_tog_reg;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			seen_tog_reg <= 1'h0;
		else if (fifo_in_valid && fifo_in_ready)
			seen_tog_reg <= req_ref;
	end

	// Request word is stable while its toggle is outstanding
	jtp_fifo #(
		.W(jtp_pkg::REQ_W),
		.D(jtp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.nrst(nrst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(req_word_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Erase occupies the executor, stalling the queue
	assign fifo_out_ready = exec_reg == jtp_pkg::EX_IDLE;
	assign op_take = fifo_out_valid && fifo_out_ready;
	assign op_cmd = fifo_out_data[jtp_pkg::REQ_W-1:jtp_pkg::PSR_W];
	assign op_addr = fifo_out_data[jtp_pkg::PSR_W-1:jtp_pkg::ROW_W];
	assign op_data = fifo_out_data[jtp_pkg::ROW_W-1:0];

	// Executor state and acknowledge toggle
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			exec_reg <= jtp_pkg::EX_IDLE;
			erase_row_reg <= '0;
			ack_tog_reg <= 1'h0;
		end
		else
		begin
			case (exec_reg)
				jtp_pkg::EX_IDLE:
				begin
					if (op_take && op_cmd == jtp_pkg::CMD_ERASE)
					begin
						exec_reg <= jtp_pkg::EX_ERASE;
						erase_row_reg <= '0;
					end
					else if (op_take)
						ack_tog_reg <= ~ack_tog_reg;
				end
				jtp_pkg::EX_ERASE:
				begin
					erase_row_reg <= erase_row_reg + 1'b1;
					if (erase_row_reg == 4'(jtp_pkg::ROWS - 1))
					begin
						exec_reg <= jtp_pkg::EX_IDLE;
						ack_tog_reg <= ~ack_tog_reg;
					end
				end
				default: exec_reg <= jtp_pkg::EX_IDLE;
			endcase
		end
	end

	// Nonvolatile rows keep their contents across reset
	always_ff @(posedge ref_clk)
	begin
		if (exec_reg == jtp_pkg::EX_ERASE)
			nv_mem[erase_row_reg] <= jtp_pkg::ROW_ERASED;
		else if (op_take && op_cmd == jtp_pkg::CMD_PROGRAM)
			nv_mem[op_addr] <= op_data;
	end

	// Verify result, stable before the acknowledge is seen
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			vdata_reg <= '0;
		else if (op_take && op_cmd == jtp_pkg::CMD_VERIFY)
			vdata_reg <= nv_mem[op_addr];
	end

	// Configuration load one cycle after reset release
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			cfg_load_reg <= 1'h1;
			pins_gpio_reg <= 1'h0;
			cfg_word_reg <= '0;
		end
		else
		begin
			cfg_load_reg <= 1'h0;
			if (cfg_load_reg)
			begin
				pins_gpio_reg <= nv_mem[jtp_pkg::CFG_ROW][jtp_pkg::CFG_GPIO_BIT];
				cfg_word_reg <= nv_mem[jtp_pkg::CFG_ROW];
			end
		end
	end

	// Busy while anything is queued or erasing
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			prog_busy_reg <= 1'h0;
		else
			prog_busy_reg <= fifo_out_valid || exec_reg != jtp_pkg::EX_IDLE ||
				fifo_in_valid;
	end

	assign pins_gpio = pins_gpio_reg;
	assign prog_busy = prog_busy_reg;
	assign cfg_word = cfg_word_reg;
endmodule : jtp_tap_isp

// [tb/jtp_ctl_model.sv]
`timescale 1ns/1ns
module jtp_ctl_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_o,
	input wire logic tdo_oe_n
);
	// Pull-up on the data-out wire, so a released line reads high
	wire logic tdo_line = tdo_oe_n ? 1'b1 : tdo_o;
	logic last_tdo;

	// Clock parked low, mode-select high at start
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One clock: inputs move with the falling edge, data-out taken at the rising edge
	task automatic cyc(input logic m, input logic d);
		tms = m;
		tdi = d;
		#16 tck = 1'b1;
		last_tdo = tdo_line;
		#16 tck = 1'b0;
	endtask : cyc

	task automatic run(input int n, input logic m);
		#3;
		repeat (n) cyc(m, 1'b1);
	endtask : run

	// Full scan from idle back to idle, LSB first; data-in kept high off the shift
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		#3;
		dout = '0;
		cyc(1'b1, 1'b1);
		if (ir)
			cyc(1'b1, 1'b1);
		cyc(1'b0, 1'b1);
		cyc(1'b0, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			cyc(i == n - 1, din[i]);
			dout[i] = last_tdo;
		end
		cyc(1'b1, 1'b1);
		cyc(1'b0, 1'b1);
	endtask : scan
endmodule : jtp_ctl_model

// [tb/jtp_tap_isp_monitor.sv]
`timescale 1ns/1ns
module jtp_tap_isp_monitor (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo_o,
	input wire logic tdo_oe_n,
	input wire logic pins_gpio,
	input wire logic prog_busy,
	input wire logic [jtp_pkg::ROW_W-1:0] cfg_word
);
	// Standard next-state tables, one nibble per state code, for mode-select 0 and 1
	localparam logic [63:0] NXT0 = 64'h1bdd_bba1_4664_4311;
	localparam logic [63:0] NXT1 = 64'h2fef_cc02_8785_5920;
	logic [3:0] st_reg;
	logic [3:0] sh_reg;
	logic [3:0] ir_reg;
	logic armed_reg;
	logic byp_w;

	// Shadow of the port state; follows the design only while pins are not freed
	always_ff @(posedge tck)
		if (!nrst)
			st_reg <= 4'h0;
		else
			st_reg <= tms ? NXT1[{st_reg, 2'b00} +: 4] : NXT0[{st_reg, 2'b00} +: 4];

	// Shadow instruction shift stage
	always_ff @(posedge tck)
		if (st_reg == 4'hb)
			sh_reg <= {tdi, sh_reg[3:1]};

	// Shadow instruction and arming, cleared in test-logic-reset
	always_ff @(posedge tck)
		if (!nrst || st_reg == 4'h0)
		begin
			ir_reg <= 4'h1;
			armed_reg <= 1'b0;
		end
		else if (st_reg == 4'hf)
		begin
			ir_reg <= sh_reg;
			armed_reg <= sh_reg == 4'h9 || (armed_reg && sh_reg inside {4'ha, 4'hb, 4'hc});
		end

	// Codes that must behave as the one-bit pass-through stage
	assign byp_w = !(ir_reg inside {4'h1, 4'h9, 4'ha, 4'hb, 4'hc})
		|| (!armed_reg && ir_reg inside {4'ha, 4'hb, 4'hc});

	AST_OE_SHIFT: assert property (@(posedge tck) disable iff (!nrst || pins_gpio)
		tdo_oe_n == !(st_reg == 4'h4 || st_reg == 4'hb))
		else $error("data-out enable disagrees with shift state");
	AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (!nrst || pins_gpio)
		st_reg == 4'hb && $past(st_reg) == 4'ha |-> tdo_o == jtp_pkg::IR_CAPTURE[0]
		##1 (st_reg != 4'hb || tdo_o == jtp_pkg::IR_CAPTURE[1]))
		else $error("instruction capture pattern wrong");
	AST_ID_FIRST: assert property (@(posedge tck) disable iff (!nrst || pins_gpio)
		st_reg == 4'h4 && $past(st_reg) == 4'h3 && ir_reg == 4'h1
		|-> tdo_o == jtp_pkg::ID_VALUE[0] ##1 (st_reg != 4'h4 || tdo_o == jtp_pkg::ID_VALUE[1]))
		else $error("identification bits wrong");
	AST_BYP_CAPTURE: assert property (@(posedge tck) disable iff (!nrst || pins_gpio)
		st_reg == 4'h4 && $past(st_reg) == 4'h3 && byp_w |-> !tdo_o)
		else $error("bypass stage did not capture zero");
	AST_BYP_DELAY: assert property (@(posedge tck) disable iff (!nrst || pins_gpio)
		st_reg == 4'h4 && $past(st_reg) == 4'h4 && byp_w |-> tdo_o == $past(tdi))
		else $error("bypass delay is not one clock");
	AST_RESET_CLEAR: assert property (@(posedge ref_clk)
		!nrst |=> !pins_gpio && !prog_busy && cfg_word == '0)
		else $error("outputs not cleared by reset");
	AST_GPIO_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		$past(nrst) && $past(nrst, 2) |-> $stable(pins_gpio) && $stable(cfg_word))
		else $error("config changed outside reset release");
	AST_GPIO_OE: assert property (@(posedge ref_clk) disable iff (!nrst)
		pins_gpio |-> tdo_oe_n)
		else $error("data-out driven with pins freed");
endmodule : jtp_tap_isp_monitor

bind jtp_tap_isp jtp_tap_isp_monitor mon (.ref_clk(ref_clk), .nrst(nrst), .tck(tck),
	.tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .pins_gpio(pins_gpio),
	.prog_busy(prog_busy), .cfg_word(cfg_word));

// [tb/jtp_tap_isp_test.sv]
`timescale 1ns/1ns
module jtp_tap_isp_test;
	logic ref_clk;
	logic nrst;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo_o;
	logic tdo_oe_n;
	logic pins_gpio;
	logic prog_busy;
	logic [jtp_pkg::ROW_W-1:0] cfg_word;
	logic [31:0] got;
	int errors;
	int total_checks;

	jtp_tap_isp uut (.ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .pins_gpio(pins_gpio),
		.prog_busy(prog_busy), .cfg_word(cfg_word));
	jtp_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n));

	// Core clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
		total_checks++;
		if (act !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, act);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// Test clock must run during reset, since its reset is synchronised
	task automatic do_reset;
		@(posedge ref_clk) nrst <= 1'b0;
		ctl.run(4, 1'b1);
		@(posedge ref_clk) nrst <= 1'b1;
		ctl.run(4, 1'b1);
		ctl.run(1, 1'b0);
	endtask : do_reset

	task automatic ir(input logic [3:0] code);
		ctl.scan(1'b1, 4, {28'h0, code}, got);
	endtask : ir

	task automatic dr(input int n, input logic [31:0] v);
		ctl.scan(1'b0, n, v, got);
	endtask : dr

	// Keep the test clock running so the acknowledge can return
	task automatic settle;
		int n;
		n = 0;
		ctl.run(12, 1'b0);
		while (prog_busy !== 1'b0 && n < 40)
		begin
			ctl.run(1, 1'b0);
			n++;
		end
		check("busy", 32'h0, {31'h0, prog_busy});
	endtask : settle

	task automatic program_row(input logic [3:0] a, input logic [15:0] d);
		ir(jtp_pkg::IR_PROGRAM);
		dr(20, {12'h0, a, d});
		settle();
	endtask : program_row

	// Second capture under verify returns the row fetched by the first
	task automatic read_row(input logic [3:0] a, input logic [15:0] exp);
		ir(jtp_pkg::IR_VERIFY);
		dr(20, {12'h0, a, 16'h0});
		settle();
		dr(20, {12'h0, a, 16'h0});
		check("row data", {16'h0, exp}, {16'h0, got[15:0]});
		settle();
	endtask : read_row

	task automatic t_ident;
		dr(32, 32'h0);
		check("reset id", jtp_pkg::ID_VALUE, got);
		ir(jtp_pkg::IR_IDCODE);
		check("ir capture", {28'h0, jtp_pkg::IR_CAPTURE}, got);
		dr(32, 32'hffff_ffff);
		check("idcode", jtp_pkg::ID_VALUE, got);
	endtask : t_ident

	// Ones-only instruction scan, then data one clock late behind a zero
	task automatic t_bypass;
		ir(4'hf);
		dr(32, 32'h9b4c_2d71);
		check("bypass", 32'h3698_5ae2, got);
	endtask : t_bypass

	task automatic t_isp;
		ir(jtp_pkg::IR_ENABLE);
		ir(jtp_pkg::IR_ERASE);
		dr(20, 32'h0);
		settle();
		program_row(4'h5, 16'hbeef);
		program_row(4'h0, 16'h1230);
		read_row(4'h5, 16'hbeef);
		read_row(4'h6, 16'h0000);
	endtask : t_isp

	// Unknown and unarmed codes pass data through and leave the array alone
	task automatic t_refuse;
		logic [3:0] codes [4] = '{4'h3, 4'ha, 4'hb, 4'hc};
		foreach (codes[i])
		begin
			ir(codes[i]);
			dr(20, 32'h000a_b5c3);
			check("refused code", 32'h0005_6b86, got);
		end
		settle();
		ir(jtp_pkg::IR_ENABLE);
		read_row(4'h5, 16'hbeef);
		read_row(4'ha, 16'h0000);
	endtask : t_refuse

	// Row 0 bit 0 frees the pins, but only from the next reset on
	task automatic t_cfg;
		do_reset();
		check("cfg word", 32'h1230, {16'h0, cfg_word});
		check("gpio off", 32'h0, {31'h0, pins_gpio});
		ir(jtp_pkg::IR_ENABLE);
		program_row(4'h0, 16'h1231);
		check("cfg held", 32'h1230, {16'h0, cfg_word});
		do_reset();
		check("gpio on", 32'h1, {31'h0, pins_gpio});
		dr(32, 32'h0);
		check("freed pins", 32'hffff_ffff, got);
	endtask : t_cfg

	initial
	begin
		nrst = 1'b0;
		errors = 0;
		total_checks = 0;
		do_reset();
		t_ident();
		t_bypass();
		t_isp();
		t_refuse();
		t_cfg();
		final_report();
	end

	// Watchdog, well beyond the expected run of about 30 us
	initial
	begin
		#400000;
		errors++;
		final_report();
	end
endmodule : jtp_tap_isp_test
